/* File: hw/imsc_top.sv */
// Impedance self-test and channel configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "imsc_regs.svh"
module imsc_top
  import imsc_pkg::*;
#(
  parameter int CLK_HZ = `IMSC_CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [2:0] nominal_load_select_o,
  output logic [2:0] modulation_switches_o,
  output logic cal_source_frequency_o,
  output logic selftest_enable_o,
  output logic drive_isolation_open_o,
  output logic drive_to_input_engage_o,
  output logic input_bias_apply_o,
  output logic [23:0] channel_config_o,
  output logic config_changed_o,
  output logic resync_command_o
);
  imsc_word_t mux_cfg;
  imsc_word_t next_mux_cfg;
  imsc_word_t chan_cfg;
  imsc_word_t next_chan_cfg;
  logic [1:0] msel;
  logic [1:0] next_msel;
  logic ack;
  logic next_ack;
  logic [31:0] next_dat;
  logic next_changed;
  logic next_resync;
  logic tick;
  logic [18:0] div_cnt;
  logic [18:0] next_div_cnt;
  logic wave;
  logic next_wave;
  logic [1:0] fsel_act;
  logic [1:0] next_fsel_act;
  logic [4:0] half_exp;
  logic [18:0] half_last;
  logic req;
  logic [31:0] wmask;

  // Master clock ticks at the selected base rate
  imsc_tick_gen #(.CLK_HZ(CLK_HZ)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .master_clock_select_i(msel),
    .tick_o(tick)
  );

  assign req = wb_cyc_i && wb_stb_i && !ack;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Wishbone decode, register writes and read mux
  always_comb begin
    next_mux_cfg = mux_cfg;
    next_chan_cfg = chan_cfg;
    next_msel = msel;
    next_ack = req;
    next_dat = 32'h0;
    next_changed = 1'b0;
    next_resync = 1'b0;
    if (req) begin
      unique case (wb_adr_i)
        `IMSC_OFF_MUX: begin
          next_dat = {8'h0, mux_cfg};
          if (wb_we_i) begin
            next_mux_cfg = (mux_cfg & ~(wmask[23:0] & `IMSC_MUX_WMASK))
                         | (wb_dat_i[23:0] & wmask[23:0] & `IMSC_MUX_WMASK);
          end
        end
        `IMSC_OFF_CHAN: begin
          next_dat = {8'h0, chan_cfg};
          if (wb_we_i) begin
            next_chan_cfg = (chan_cfg & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
            next_changed = 1'b1;
          end
        end
        `IMSC_OFF_CTRL: begin
          next_dat = {30'h0, msel};
          if (wb_we_i && wb_sel_i[0]) begin
            next_msel = wb_dat_i[`IMSC_CTRL_MSEL +: 2];
            next_resync = wb_dat_i[`IMSC_CTRL_SYNC];
          end
        end
        `IMSC_OFF_STAT: next_dat = {29'h0, fsel_act, wave};
        default: next_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_cfg <= `IMSC_MUX_RST;
      chan_cfg <= `IMSC_CHAN_RST;
      msel <= 2'h0;
      ack <= 1'b0;
      wb_dat_o <= 32'h0;
      config_changed_o <= 1'b0;
      resync_command_o <= 1'b0;
    end else begin
      mux_cfg <= next_mux_cfg;
      chan_cfg <= next_chan_cfg;
      msel <= next_msel;
      ack <= next_ack;
      wb_dat_o <= next_dat;
      config_changed_o <= next_changed;
      resync_command_o <= next_resync;
    end
  end

  assign wb_ack_o = ack;

  // Half period is 2^(n-1) ticks for a division by 2^n
  assign half_exp = 5'(`IMSC_EXP0 - 1) + {2'h0, fsel_act, 1'b0};
  assign half_last = 19'((32'h1 << half_exp) - 32'h1);

  // Square wave divider; selection only latched on resync or at a period boundary
  always_comb begin
    next_div_cnt = div_cnt;
    next_wave = wave;
    next_fsel_act = fsel_act;
    if (resync_command_o) begin
      next_div_cnt = 19'h0;
      next_wave = 1'b0;
      next_fsel_act = mux_cfg[`IMSC_FSEL_LSB +: 2];
    end else if (tick) begin
      if (div_cnt == half_last) begin
        next_div_cnt = 19'h0;
        next_wave = !wave;
        if (wave) begin
          next_fsel_act = mux_cfg[`IMSC_FSEL_LSB +: 2];
        end
      end else begin
        next_div_cnt = div_cnt + 19'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 19'h0;
      wave <= 1'b0;
      fsel_act <= 2'h0;
    end else begin
      div_cnt <= next_div_cnt;
      wave <= next_wave;
      fsel_act <= next_fsel_act;
    end
  end

  // Analogue switch controls
  always_comb begin
    nominal_load_select_o = mux_cfg[`IMSC_NOM_LSB +: 3];
    selftest_enable_o = mux_cfg[`IMSC_EN_BIT];
    drive_isolation_open_o = selftest_enable_o;
    drive_to_input_engage_o = selftest_enable_o;
    input_bias_apply_o = selftest_enable_o;
    modulation_switches_o = 3'h0;
    if (selftest_enable_o && !mux_cfg[`IMSC_MOD_LSB + 2] && wave) begin
      modulation_switches_o = 3'h1 << mux_cfg[`IMSC_MOD_LSB +: 2];
    end
    cal_source_frequency_o = wave;
    channel_config_o = chan_cfg;
  end

  // Checks
  a_mux_reset: assert property (@(posedge clk_i) $fell(rst_i) |->
    mux_cfg == `IMSC_MUX_RST) else $error("mux reset value wrong");
  a_mod_open: assert property (@(posedge clk_i) disable iff (rst_i)
    mux_cfg[6] |-> modulation_switches_o == 3'h0) else $error("mod switch closed");
  a_depth_reset: assert property (@(posedge clk_i) $fell(rst_i) |->
    mux_cfg[6:4] == 3'h4) else $error("depth reset wrong");
  a_fsel_reset: assert property (@(posedge clk_i) $fell(rst_i) |->
    mux_cfg[1:0] == 2'h0) else $error("freq select reset wrong");
  a_wave_half: assert property (@(posedge clk_i) disable iff (rst_i || resync_command_o)
    tick && div_cnt == half_last |=> $changed(wave)) else $error("wave not toggled");
  a_wave_hold: assert property (@(posedge clk_i) disable iff (rst_i || resync_command_o)
    !tick |=> $stable(wave)) else $error("wave glitch");
  a_chan_write: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && wb_adr_i == `IMSC_OFF_CHAN && wb_sel_i == 4'hf
    |=> chan_cfg == $past(wb_dat_i[23:0]) && config_changed_o) else $error("chan write");
  a_resync_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    resync_command_o |=> div_cnt == 19'h0 && !wave) else $error("resync failed");
  a_st_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_isolation_open_o == mux_cfg[11] && input_bias_apply_o == mux_cfg[11])
    else $error("self-test gate");
  a_div_range: assert property (@(posedge clk_i) disable iff (rst_i)
    div_cnt <= half_last) else $error("divider overrun");
  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  c_wave_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(wave));
  c_mod_active: cover property (@(posedge clk_i) disable iff (rst_i) modulation_switches_o != 3'h0);
  c_resync: cover property (@(posedge clk_i) disable iff (rst_i) resync_command_o);
  c_chan_wr: cover property (@(posedge clk_i) disable iff (rst_i) config_changed_o);
  c_fsel_slow: cover property (@(posedge clk_i) disable iff (rst_i) fsel_act != 2'h0);

  // Bus answer timing: ack follows a taken request by exactly one cycle.
  // A master that holds stb after ack gets no ack in the next cycle, because
  // the request term masks itself while ack stands; a cycle later it is taken again.
  a_ack_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_spurious: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:24] == 8'h0)
    else $error("read data upper byte set");
  a_idle_dat: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> wb_dat_o == 32'h0)
    else $error("read data not cleared");

  // Read paths return the register as it stood when the request was taken
  a_read_mux: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_adr_i == `IMSC_OFF_MUX |=> wb_dat_o == {8'h0, $past(mux_cfg)})
    else $error("mux read data wrong");
  a_read_chan: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_adr_i == `IMSC_OFF_CHAN |=> wb_dat_o == {8'h0, $past(chan_cfg)})
    else $error("chan read data wrong");
  a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    req && (wb_adr_i < `IMSC_OFF_MUX || wb_adr_i > `IMSC_OFF_STAT) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  // Register writes land only when addressed, and only in writable bits
  a_mux_write: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && wb_adr_i == `IMSC_OFF_MUX && wb_sel_i == 4'hf
    |=> mux_cfg == ($past(wb_dat_i[23:0]) & `IMSC_MUX_WMASK))
    else $error("mux write wrong");
  a_mux_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_adr_i == `IMSC_OFF_MUX) |=> $stable(mux_cfg))
    else $error("mux changed without write");
  a_mux_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    (mux_cfg & ~`IMSC_MUX_WMASK) == 24'h0)
    else $error("unused mux bit set");
  a_chan_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_adr_i == `IMSC_OFF_CHAN) |=> $stable(chan_cfg))
    else $error("chan changed without write");
  a_msel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_adr_i == `IMSC_OFF_CTRL) |=> $stable(msel))
    else $error("master select changed");

  // Change flag and resync pulse both stand with the ack of their write
  a_changed_src: assert property (@(posedge clk_i) disable iff (rst_i)
    config_changed_o |-> $past(req && wb_we_i && wb_adr_i == `IMSC_OFF_CHAN))
    else $error("change flag without write");
  a_changed_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    config_changed_o |-> wb_ack_o)
    else $error("change flag off ack");
  a_resync_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    resync_command_o |-> wb_ack_o)
    else $error("resync off ack");
  a_resync_src: assert property (@(posedge clk_i) disable iff (rst_i)
    resync_command_o |-> $past(req && wb_we_i && wb_adr_i == `IMSC_OFF_CTRL && wb_dat_i[4]))
    else $error("resync without command");

  // Frequency selection is adopted only at resync or a falling wave edge,
  // so a new rate never cuts a half period short
  a_fsel_adopt: assert property (@(posedge clk_i) disable iff (rst_i)
    resync_command_o |=> fsel_act == $past(mux_cfg[1:0]))
    else $error("resync did not adopt rate");
  a_fsel_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    !resync_command_o && !(tick && div_cnt == half_last && wave) |=> $stable(fsel_act))
    else $error("rate changed mid period");

  // Half period lengths for the four rates
  a_half_sel0: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel_act == 2'h0 |-> half_last == 19'd4095)
    else $error("half period sel 0");
  a_half_sel1: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel_act == 2'h1 |-> half_last == 19'd16383)
    else $error("half period sel 1");
  a_half_sel2: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel_act == 2'h2 |-> half_last == 19'd65535)
    else $error("half period sel 2");
  a_half_sel3: assert property (@(posedge clk_i) disable iff (rst_i)
    fsel_act == 2'h3 |-> half_last == 19'd262143)
    else $error("half period sel 3");

  // Divider advances once per master tick and otherwise holds
  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i || resync_command_o)
    tick && div_cnt != half_last |=> div_cnt == $past(div_cnt) + 19'h1)
    else $error("divider step wrong");
  a_cnt_idle: assert property (@(posedge clk_i) disable iff (rst_i || resync_command_o)
    !tick |=> $stable(div_cnt))
    else $error("divider moved without tick");
  a_cal_out: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_source_frequency_o == wave)
    else $error("cal output differs from wave");

  // Switch outputs: at most one modulation switch, gated by enable and wave
  a_mod_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(modulation_switches_o))
    else $error("several mod switches closed");
  a_mod_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !selftest_enable_o |-> modulation_switches_o == 3'h0)
    else $error("mod switch closed while disabled");
  a_mod_code0: assert property (@(posedge clk_i) disable iff (rst_i)
    selftest_enable_o && wave && mux_cfg[6:4] == 3'h0 |-> modulation_switches_o == 3'h1)
    else $error("depth 0 switch wrong");
  a_mod_code1: assert property (@(posedge clk_i) disable iff (rst_i)
    selftest_enable_o && wave && mux_cfg[6:4] == 3'h1 |-> modulation_switches_o == 3'h2)
    else $error("depth 1 switch wrong");
  a_mod_code2: assert property (@(posedge clk_i) disable iff (rst_i)
    selftest_enable_o && wave && mux_cfg[6:4] == 3'h2 |-> modulation_switches_o == 3'h4)
    else $error("depth 2 switch wrong");
  a_nom_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    nominal_load_select_o == mux_cfg[10:8])
    else $error("nominal load output wrong");
  a_engage_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_to_input_engage_o == mux_cfg[11])
    else $error("drive to input gate wrong");
  a_chan_out: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_config_o == chan_cfg)
    else $error("channel config output wrong");
endmodule
`default_nettype wire

/* File: hw/imsc_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef IMSC_REGS_SVH
`define IMSC_REGS_SVH
`define IMSC_OFF_MUX 8'h17
`define IMSC_OFF_CHAN 8'h18
`define IMSC_OFF_CTRL 8'h19
`define IMSC_OFF_STAT 8'h1a
`define IMSC_MUX_RST 24'h300040
`define IMSC_CHAN_RST 24'h200000
`define IMSC_MUX_WMASK 24'h3f3f73
`define IMSC_NOM_LSB 8
`define IMSC_EN_BIT 11
`define IMSC_MOD_LSB 4
`define IMSC_FSEL_LSB 0
`define IMSC_CHAN_RATE 23
`define IMSC_CHAN_ANALOG_HIGHPASS_SELECT 20
`define IMSC_CHAN_XBIAS 19
`define IMSC_CHAN_LN 18
`define IMSC_CHAN_GAIN 16
`define IMSC_CHAN_DIGITAL_HIGHPASS_SELECT 14
`define IMSC_CHAN_DIGITAL_LOWPASS_SELECT 12
`define IMSC_CHAN_FCG 8
`define IMSC_CHAN_MON 7
`define IMSC_CHAN_MAG 4
`define IMSC_CHAN_PH 0
`define IMSC_CTRL_MSEL 0
`define IMSC_CTRL_SYNC 4
`define IMSC_CLK_HZ 25000000
`define IMSC_EXP0 13
`endif

/* File: hw/imsc_pkg.sv */
// Types for the impedance self-test configuration block
package imsc_pkg;
  typedef enum logic [1:0] {IMSC_M32768, IMSC_M32000A, IMSC_M32000B, IMSC_M31968} imsc_msel_e;
  typedef logic [23:0] imsc_word_t;
endpackage

/* File: hw/imsc_tick_gen.sv */
// Master clock tick generator: fractional accumulator producing one-cycle enables
`timescale 1ns/1ps
`default_nettype none
`include "imsc_regs.svh"
module imsc_tick_gen
  import imsc_pkg::*;
#(
  parameter int CLK_HZ = `IMSC_CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] master_clock_select_i,
  output logic tick_o
);
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [31:0] step;
  logic next_tick;

  // Base frequency per master clock selection
  always_comb begin
    unique case (imsc_msel_e'(master_clock_select_i))
      IMSC_M32768: step = 32'd32768;
      IMSC_M32000A: step = 32'd32000;
      IMSC_M32000B: step = 32'd32000;
      IMSC_M31968: step = 32'd31968;
    endcase
  end

  // Accumulate base rate, wrap at system clock rate
  always_comb begin
    next_tick = 1'b0;
    next_acc = acc + step;
    if (next_acc >= 32'(CLK_HZ)) begin
      next_acc = next_acc - 32'(CLK_HZ);
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      acc <= next_acc;
      tick_o <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* File: bench/test_impedance_selftest_config_regs.sv */
// Self-checking bench for the impedance self-test configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_impedance_selftest_config_regs;
  import imsc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd, dat_o;
  logic ack, wave, st_en, iso, d2i, bias, chg, rsync, rs_seen;
  logic [2:0] nom, sw;
  logic [23:0] chan;
  imsc_word_t chan_exp;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int hi, lo;

  // Tick at the master clock rate so one divider step is one bench cycle
  imsc_top #(.CLK_HZ(32768)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .nominal_load_select_o(nom), .modulation_switches_o(sw),
    .cal_source_frequency_o(wave), .selftest_enable_o(st_en),
    .drive_isolation_open_o(iso), .drive_to_input_engage_o(d2i),
    .input_bias_apply_o(bias), .channel_config_o(chan), .config_changed_o(chg),
    .resync_command_o(rsync)
  );

  always #20 clk_i = ~clk_i;

  // Hang guard; the full sequence needs about 45000 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // One classic Wishbone cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    `CHK("ack", 1'b1, ack)
    rd = dat_o;
    rs_seen = rsync;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Count cycles while the calibration wave holds one level
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (wave === v && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task end_of_test;
    $display("error_cnt %0d n_compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence of register accesses and waveform checks
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h17, 32'h0);
    `CHK("mux reset", 32'h00300040, rd)
    `CHK("nominal reset", 3'b000, nom)
    `CHK("switches reset", 3'b000, sw)
    wb(1'b0, 8'h18, 32'h0);
    `CHK("chan reset", 32'h00200000, rd)
    chan_exp = {1'b1, 3'b101, 1'b1, 1'b0, 2'b11, 2'b01, 2'b10, 4'h9, 1'b1, 3'b011, 4'h6};
    wb(1'b1, 8'h18, {8'h00, chan_exp});
    `CHK("config changed", 1'b1, chg)
    `CHK("chan out", chan_exp, chan)
    @(posedge clk_i);
    `CHK("config changed end", 1'b0, chg)
    wb(1'b0, 8'h18, 32'h0);
    `CHK("chan read", {8'h00, chan_exp}, rd)
    wb(1'b1, 8'h05, 32'hffffffff);
    wb(1'b0, 8'h05, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    // Bits 3:2 are unused and must read back as zero; depth is 001
    wb(1'b1, 8'h17, 32'h00300d1c);
    wb(1'b0, 8'h17, 32'h0);
    `CHK("mux read", 32'h00300d10, rd)
    `CHK("nominal", 3'b101, nom)
    `CHK("selftest gates", 4'hf, {st_en, iso, d2i, bias})
    wb(1'b1, 8'h19, 32'h10);
    `CHK("resync", 1'b1, rs_seen)
    @(posedge clk_i);
    run_len(1'b0, lo);
    `CHK("switch depth 1", 3'b010, sw)
    run_len(1'b1, hi);
    run_len(1'b0, lo);
    `CHK("high fsel 0", 4096, hi)
    `CHK("low fsel 0", 4096, lo)
    // Depth 100 with a slower rate: no switch may close
    wb(1'b1, 8'h17, 32'h00300c41);
    wb(1'b1, 8'h19, 32'h10);
    @(posedge clk_i);
    run_len(1'b0, lo);
    `CHK("switches open", 3'b000, sw)
    run_len(1'b1, hi);
    `CHK("high fsel 1", 16384, hi)
    end_of_test();
  end
endmodule
`default_nettype wire
